// ==== design/ietp_controller.sv ====
// Controller end: makes SCL by a divider and runs start, stop, byte
// write and byte read primitives ordered through a small register port.
// Assumes the bus pull-up lives in the interface.
`timescale 1ns/100ps
module ietp_controller #(
  parameter int QTR_CYC = ietp_pkg::SCL_QTR_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Bus
  ietp_if.ctl             bus
);
  import ietp_pkg::*;

  typedef struct packed {
    ietp_ctl_state_e state;
    ietp_op_e        op;
    logic            ack_tx;
    logic [7:0]      tick;
    logic [1:0]      step;
    logic [3:0]      bitn;
    logic [7:0]      tx;
    logic [7:0]      rx;
    logic            ack_rx;
    logic [7:0]      rdata;
    logic            scl_out;
    logic            sda_oe_n;
    logic            sda_out;
    logic            sda_s1;
    logic            sda_s2;
  } ietp_ctl_s;

  localparam ietp_ctl_s RST_VAL = '{state: CS_IDLE, op: OP_START,
    tx: TXDATA_RST, scl_out: 1'b1, sda_oe_n: 1'b1, sda_s1: 1'b1,
    sda_s2: 1'b1, default: '0};

  ietp_ctl_s r_reg;
  ietp_ctl_s r_next;

  // Line levels for one quarter step of a primitive: {scl, sda_oe_n}.
  function automatic logic [1:0] drive(input ietp_op_e op,
      input logic [1:0] step, input logic [3:0] bitn,
      input logic [7:0] tx, input logic ack_tx);
    logic scl_hi;
    scl_hi = (step == 2'h1) || (step == 2'h2);
    unique case (op)
      OP_START: drive = {scl_hi, step < 2'h2};
      OP_STOP:  drive = {step != 2'h0, step > 2'h1};
      OP_WRITE: drive = {scl_hi, (bitn == 4'h8) | tx[7]};
      OP_READ:  drive = {scl_hi, (bitn == 4'h8) ? ack_tx : 1'b1};
    endcase
  endfunction : drive

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register access, then the quarter-step sequencer.
  always_comb begin
    r_next        = r_reg;
    r_next.sda_s1 = bus.sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.rdata  = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_TXDATA: r_next.rdata = r_reg.tx;
        REG_RXDATA: r_next.rdata = r_reg.rx;
        REG_STATUS: begin
          r_next.rdata[STAT_BUSY_BIT] = (r_reg.state == CS_RUN);
          r_next.rdata[STAT_ACK_BIT]  = r_reg.ack_rx;
        end
        default: r_next.rdata = 8'h00;
      endcase
    end
    if (r_reg.state == CS_IDLE) begin
      // Commands and data are taken only while idle.
      if (reg_wr && reg_addr == REG_TXDATA) begin
        r_next.tx = reg_wdata;
      end
      if (reg_wr && reg_addr == REG_CMD) begin
        r_next.op     = ietp_op_e'(reg_wdata[1:0]);
        r_next.ack_tx = reg_wdata[CMD_ACK_BIT];
        r_next.state  = CS_RUN;
        r_next.tick   = 8'h00;
        r_next.step   = 2'h0;
        r_next.bitn   = 4'h0;
      end
    end else begin
      r_next.tick = r_reg.tick + 8'h01;
      if (r_reg.tick == 8'(QTR_CYC - 1)) begin
        r_next.tick = 8'h00;
        r_next.step = r_reg.step + 2'h1;
        // Sample while SCL is high, before its fall.
        if (r_reg.step == 2'h2) begin
          if (r_reg.bitn == 4'h8) begin
            r_next.ack_rx = r_reg.sda_s2;
          end else if (r_reg.op == OP_READ) begin
            r_next.rx = {r_reg.rx[6:0], r_reg.sda_s2};
          end
        end
        if (r_reg.step == 2'h3) begin
          if (r_reg.op == OP_START || r_reg.op == OP_STOP ||
              r_reg.bitn == 4'h8) begin
            r_next.state = CS_IDLE;
          end else begin
            r_next.bitn = r_reg.bitn + 4'h1;
            if (r_reg.op == OP_WRITE) begin
              r_next.tx = {r_reg.tx[6:0], 1'b0};
            end
          end
        end
      end
    end
    // Data changes only in the SCL-low quarters of a byte.
    if (r_next.state == CS_RUN) begin
      {r_next.scl_out, r_next.sda_oe_n} = drive(r_next.op, r_next.step,
        r_next.bitn, r_next.tx, r_next.ack_tx);
    end
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= RST_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata        = r_reg.rdata;
  assign bus.scl          = r_reg.scl_out;
  assign bus.ctl_sda_out  = r_reg.sda_out;
  assign bus.ctl_sda_oe_n = r_reg.sda_oe_n;

endmodule : ietp_controller

// ==== design/ietp_target.sv ====
// Memory target end: start/stop detection, address word match, per-byte
// acknowledge, page buffer, write protect and the timed write cycle.
// Assumes an external byte array with an asynchronous read port.
`timescale 1ns/100ps
module ietp_target #(
  parameter int         WC_CYCLES  = ietp_pkg::TWC_CYC,
  parameter int         PAGE_BYTES = ietp_pkg::PAGE_BYTES,
  parameter int         ADDR_BITS  = ietp_pkg::ADDR_BITS,
  parameter logic [3:0] TYPE_CODE  = ietp_pkg::DEV_TYPE_CODE
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Strap and protect pins
  input  wire logic                 select_pin_high,
  input  wire logic                 select_pin_mid,
  input  wire logic                 select_pin_low,
  input  wire logic                 write_protect,
  // Memory array port
  output logic      [ADDR_BITS-1:0] mem_rd_addr,
  input  wire logic [7:0]           mem_rd_data,
  output logic                      mem_we,
  output logic      [ADDR_BITS-1:0] mem_wa,
  output logic      [7:0]           mem_wd,
  output logic                      write_busy,
  // Bus
  ietp_if.dev                       bus
);
  import ietp_pkg::*;

  localparam int PW = $clog2(PAGE_BYTES);
  localparam int TW = $clog2(WC_CYCLES + 1);

  typedef struct packed {
    ietp_dev_state_e                 state;
    logic                            scl_s1;
    logic                            scl_s2;
    logic                            scl_d;
    logic                            sda_s1;
    logic                            sda_s2;
    logic                            sda_d;
    logic                            wp_s1;
    logic                            wp_s2;
    logic [2:0]                      sel_s1;
    logic [2:0]                      sel_s2;
    logic [3:0]                      bitcnt;
    logic [7:0]                      shift;
    logic [1:0]                      byte_idx;
    logic                            rw;
    logic [ADDR_BITS-1:0]            addr;
    logic [PAGE_BYTES-1:0][7:0]      page;
    logic [PAGE_BYTES-1:0]           valid;
    logic [TW-1:0]                   timer;
    logic                            sda_oe_n;
    logic                            sda_out;
    logic                            mem_we;
    logic [ADDR_BITS-1:0]            mem_wa;
    logic [7:0]                      mem_wd;
  } ietp_dev_s;

  localparam ietp_dev_s RST_VAL = '{state: ST_IDLE, scl_s1: 1'b1,
    scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
    sda_oe_n: 1'b1, default: '0};

  ietp_dev_s r_reg;
  ietp_dev_s r_next;

  logic          scl_rise;
  logic          scl_fall;
  logic          start_seen;
  logic          stop_seen;
  logic [PW-1:0] off;
  logic [PW-1:0] cidx;

  // ----------------------------------------------------------------
  // Bus event decode
  // ----------------------------------------------------------------
  // Edges are taken from the second sync stage and its delayed copy.
  assign scl_rise   = r_reg.scl_s2 & ~r_reg.scl_d;
  assign scl_fall   = ~r_reg.scl_s2 & r_reg.scl_d;
  assign start_seen = r_reg.scl_s2 & r_reg.scl_d &
                      r_reg.sda_d & ~r_reg.sda_s2;
  assign stop_seen  = r_reg.scl_s2 & r_reg.scl_d &
                      ~r_reg.sda_d & r_reg.sda_s2;
  assign off        = r_reg.addr[PW-1:0];
  assign cidx       = r_reg.timer[PW-1:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Synchronisers, then the transaction sequencer.
  always_comb begin
    r_next        = r_reg;
    r_next.scl_s1 = bus.scl;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d  = r_reg.scl_s2;
    r_next.sda_s1 = bus.sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d  = r_reg.sda_s2;
    r_next.wp_s1  = write_protect;
    r_next.wp_s2  = r_reg.wp_s1;
    // An unconnected strap is pulled low outside, so it compares as 0.
    r_next.sel_s1 = {select_pin_high, select_pin_mid,
                     select_pin_low};
    r_next.sel_s2 = r_reg.sel_s1;
    r_next.mem_we = 1'b0;
    if (r_reg.state == ST_BUSY) begin
      // Bus activity is not decoded, so polls go unacknowledged.
      r_next.timer = r_reg.timer + TW'(1);
      if (r_reg.timer < TW'(PAGE_BYTES) && r_reg.valid[cidx]) begin
        r_next.mem_we = 1'b1;
        r_next.mem_wa = {r_reg.addr[ADDR_BITS-1:PW], cidx};
        r_next.mem_wd = r_reg.page[cidx];
      end
      if (r_reg.timer == TW'(WC_CYCLES - 1)) begin
        r_next.state = ST_IDLE;
        r_next.valid = '0;
      end
    end else if (start_seen) begin
      r_next.state    = ST_RX;
      r_next.bitcnt   = 4'h0;
      r_next.byte_idx = 2'h0;
      r_next.valid    = '0;
      r_next.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      r_next.sda_oe_n = 1'b1;
      r_next.timer    = '0;
      if (|r_reg.valid && !r_reg.wp_s2) begin
        r_next.state = ST_BUSY;
      end else begin
        r_next.state = ST_IDLE;
        r_next.valid = '0;
      end
    end else begin
      unique case (r_reg.state)
        ST_IDLE: begin
          r_next.sda_oe_n = 1'b1;
        end
        ST_RX: begin
          if (scl_rise && r_reg.bitcnt < 4'h8) begin
            r_next.shift  = {r_reg.shift[6:0], r_reg.sda_s2};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (scl_fall && r_reg.bitcnt == 4'h8) begin
            r_next.state    = ST_ACK;
            r_next.sda_oe_n = 1'b0;
            if (r_reg.byte_idx != 2'h3) begin
              r_next.byte_idx = r_reg.byte_idx + 2'h1;
            end
            unique case (r_reg.byte_idx)
              2'h0: begin
                r_next.rw = r_reg.shift[0];
                if (r_reg.shift[7:4] != TYPE_CODE ||
                    r_reg.shift[3:1] != r_reg.sel_s2) begin
                  r_next.state    = ST_IDLE;
                  r_next.sda_oe_n = 1'b1;
                end
              end
              2'h1: begin
                r_next.addr[ADDR_BITS-1:8] =
                  r_reg.shift[ADDR_BITS-9:0];
              end
              2'h2: begin
                r_next.addr[7:0] = r_reg.shift;
              end
              default: begin
                if (r_reg.wp_s2) begin
                  r_next.state    = ST_IDLE;
                  r_next.sda_oe_n = 1'b1;
                end else begin
                  r_next.page[off]  = r_reg.shift;
                  r_next.valid[off] = 1'b1;
                  r_next.addr[PW-1:0] = off + PW'(1);
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.rw) begin
              r_next.state    = ST_TX;
              r_next.shift    = mem_rd_data;
              r_next.sda_oe_n = mem_rd_data[7];
            end else begin
              r_next.state    = ST_RX;
              r_next.sda_oe_n = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (scl_fall && r_reg.bitcnt == 4'h8) begin
            r_next.state    = ST_RACK;
            r_next.sda_oe_n = 1'b1;
          end else if (scl_fall) begin
            r_next.shift    = {r_reg.shift[6:0], 1'b0};
            r_next.sda_oe_n = r_reg.shift[6];
          end
        end
        ST_RACK: begin
          if (scl_rise && !r_reg.sda_s2) begin
            r_next.state = ST_ACK;
            r_next.addr  = r_reg.addr + ADDR_BITS'(1);
          end else if (scl_rise) begin
            r_next.state = ST_IDLE;
          end
        end
        default: begin
          r_next.state = ST_IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= RST_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mem_rd_addr      = r_reg.addr;
  assign mem_we           = r_reg.mem_we;
  assign mem_wa           = r_reg.mem_wa;
  assign mem_wd           = r_reg.mem_wd;
  assign write_busy       = r_reg.state[DEV_BUSY_BIT];
  assign bus.dev_sda_out  = r_reg.sda_out;
  assign bus.dev_sda_oe_n = r_reg.sda_oe_n;

endmodule : ietp_target

// ==== pkg/ietp_if.sv ====
// Two-wire bus between the controller end and the memory target end.
// Both ends drive the data line open-drain; SCL is driven by the
// controller only.
`timescale 1ns/100ps
interface ietp_if;
  logic scl;
  logic ctl_sda_out;
  logic ctl_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic sda;

  // Wired-AND line with a pull-up: any enabled low output wins.
  assign sda = (ctl_sda_oe_n | ctl_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport ctl (
    output scl,
    output ctl_sda_out,
    output ctl_sda_oe_n,
    input  sda
  );

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );
endinterface : ietp_if

// ==== pkg/ietp_pkg.sv ====
// Shared constants of the two-wire memory target and its controller.
// Assumes a 20 MHz system clock on both ends.
package ietp_pkg;

  // ----------------------------------------------------------------
  // Framing and array geometry
  // ----------------------------------------------------------------
  localparam int BYTE_BITS  = 8;
  localparam int PAGE_BYTES = 64;
  localparam int ADDR_BITS  = 14;
  // Device type code; the value is arbitrary.
  localparam logic [3:0] DEV_TYPE_CODE = 4'h6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_NS           = 50;
  localparam int TWC_MS            = 5;
  localparam int TWC_CYC           = TWC_MS * 1000000 / MCLK_NS;
  localparam int SCL_MIN_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC       =
    (SCL_MIN_PERIOD_NS + 4 * MCLK_NS - 1) / (4 * MCLK_NS);

  // ----------------------------------------------------------------
  // Target states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_RACK = 6'h10,
    ST_BUSY = 6'h20
  } ietp_dev_state_e;
  localparam int DEV_BUSY_BIT = 5;

  // ----------------------------------------------------------------
  // Controller register port
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CMD    = 2'h0;
  localparam logic [1:0] REG_TXDATA = 2'h1;
  localparam logic [1:0] REG_RXDATA = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam int CMD_ACK_BIT   = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT  = 1;
  localparam logic [7:0] TXDATA_RST = 8'h00;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } ietp_op_e;

  typedef enum logic [1:0] {
    CS_IDLE = 2'h1,
    CS_RUN  = 2'h2
  } ietp_ctl_state_e;

endpackage : ietp_pkg

// ==== tb/ietp_chk.sv ====
// Checker for the two-wire link between the controller and the target.
// Assumes it sits beside the link interface, watching its plain signals
// and the target's write-cycle outputs, all in the mclk domain.
`timescale 1ns/100ps
module ietp_chk #(
  parameter int         WC_CYC    = 100000,
  parameter logic [3:0] TYPE_CODE = 4'h6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  // Target write cycle
  input wire logic write_busy,
  input wire logic mem_we
);
  // ----------------------------------------------------------------
  // Bit tracking
  // ----------------------------------------------------------------
  logic       scl_reg;
  logic       sda_reg;
  logic       reject_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  int         busy_cnt_reg;
  logic       start_seen;
  logic       scl_rise;

  assign start_seen = scl && scl_reg && sda_reg && !sda;
  assign scl_rise   = scl && !scl_reg;

  // Counts bits after a start and flags a first word of a foreign type.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
      reject_reg   <= 1'b0;
      bit_cnt_reg  <= 4'hF;
      shift_reg    <= 8'h00;
      busy_cnt_reg <= 0;
    end else begin
      scl_reg      <= scl;
      sda_reg      <= sda;
      busy_cnt_reg <= write_busy ? busy_cnt_reg + 1 : 0;
      if (start_seen) begin
        bit_cnt_reg <= 4'h0;
        reject_reg  <= 1'b0;
      end else if (scl_rise && bit_cnt_reg != 4'hF) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg   <= {shift_reg[6:0], sda};
        if (bit_cnt_reg == 4'h7 && shift_reg[6:3] != TYPE_CODE) begin
          reject_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  data_change_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("Target moved the data line while the clock was high.");
  drive_low_a: assert property (!dev_sda_oe_n |-> !dev_sda_out)
    else $error("Target drives a high level onto the data line.");
  busy_quiet_a: assert property (write_busy |-> dev_sda_oe_n)
    else $error("Target answered on the link during its write cycle.");
  busy_len_a: assert property (write_busy |-> busy_cnt_reg < WC_CYC)
    else $error("Write cycle ran past its maximum length.");
  busy_stop_a: assert property ($rose(write_busy) |-> scl && sda)
    else $error("Write cycle began without a stop on the link.");
  commit_busy_a: assert property (mem_we |-> write_busy)
    else $error("Array written outside the write cycle.");
  start_quiet_a: assert property (start_seen |=> dev_sda_oe_n [*8])
    else $error("Target drove the line right after a start.");
  reject_quiet_a: assert property (reject_reg |-> dev_sda_oe_n)
    else $error("Target answered a word of another device type.");

  write_cycle_c: cover property ($rose(write_busy));
  reject_c: cover property (reject_reg && scl_rise);
  ack_c: cover property (!dev_sda_oe_n && scl_rise);
endmodule : ietp_chk

// ==== tb/ietp_tb_top.sv ====
// Self-checking bench: controller and target joined by the link.
// Assumes the controller register map and op codes of ietp_pkg.
`timescale 1ns/100ps
module ietp_tb_top;
  import ietp_pkg::*;
  localparam int WC = 1500;
  logic        mclk      = 1'b0;
  logic        rst       = 1'b1;
  logic [1:0]  reg_addr  = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        rd_chk    = 1'b0;
  logic        chk_d     = 1'b0;
  logic [2:0]  sel       = 3'h0;
  logic        wp        = 1'b0;
  logic [7:0]  reg_rdata;
  logic [13:0] mem_rd_addr;
  logic [13:0] mem_wa;
  logic [7:0]  mem_wd;
  logic [7:0]  mem_rd_data;
  logic        mem_we;
  logic        write_busy;
  logic [7:0]  mem [0:16383];
  logic [15:0] exp_q [$];
  logic [15:0] e_cur;
  int          err_total   = 0;
  int          checks_done = 0;

  ietp_if bus_if ();
  ietp_controller ietp_controller_inst (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus_if.ctl));
  ietp_target #(.WC_CYCLES(WC)) ietp_target_inst (.mclk(mclk), .rst(rst),
    .select_pin_high(sel[2]), .select_pin_mid(sel[1]),
    .select_pin_low(sel[0]), .write_protect(wp),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_we(mem_we),
    .mem_wa(mem_wa), .mem_wd(mem_wd), .write_busy(write_busy),
    .bus(bus_if.dev));
  ietp_chk #(.WC_CYC(WC), .TYPE_CODE(DEV_TYPE_CODE)) ietp_chk_inst (
    .mclk(mclk), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .dev_sda_out(bus_if.dev_sda_out), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
    .write_busy(write_busy), .mem_we(mem_we));

  // ----------------------------------------------------------------
  // Clock, array and result monitor
  // ----------------------------------------------------------------
  always #25 mclk = ~mclk;
  assign mem_rd_data = mem[mem_rd_addr];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Byte array behind the target, written on its commit pulse.
  always @(posedge mclk) if (mem_we === 1'b1) mem[mem_wa] <= mem_wd;
  always @(posedge mclk) chk_d <= reg_rd & rd_chk;
  // Compares each checked read against the oldest note, under its mask.
  always @(negedge mclk) begin
    if (chk_d) begin
      e_cur = exp_q.pop_front();
      checks_done++;
      if ((reg_rdata & e_cur[15:8]) !== e_cur[7:0]) begin
        err_total++;
        $display("Error %0t: read %h, expected %h", $time, reg_rdata,
                 e_cur[7:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register and link tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic c, input logic [15:0] e,
                    output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_chk   <= c;
    if (c) exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask : rd

  // Issues one link primitive and waits for the controller to go idle.
  task automatic op(input ietp_op_e o, input logic ack, input logic [7:0] d);
    logic [7:0] v;
    int         n;
    if (o == OP_WRITE) wr(REG_TXDATA, d);
    wr(REG_CMD, {5'h00, ack, o});
    v = 8'h01;
    for (n = 0; n < 400 && v[0] !== 1'b0; n++) rd(REG_STATUS, 1'b0, 0, v);
    // A primitive that never finishes counts as a mismatch.
    if (v[0] !== 1'b0) begin
      err_total++;
      $display("Error %0t: controller stuck busy", $time);
    end
  endtask : op

  function automatic logic [7:0] dw(input logic rw);
    return {DEV_TYPE_CODE, sel, rw};
  endfunction : dw

  task automatic wb(input logic [7:0] d, input logic ack);
    logic [7:0] v;
    op(OP_WRITE, 1'b0, d);
    rd(REG_STATUS, 1'b1, {8'h02, 6'h00, ack, 1'b0}, v);
  endtask : wb

  task automatic rb(input logic ack, input logic [7:0] e);
    logic [7:0] v;
    op(OP_READ, ack, 8'h00);
    rd(REG_RXDATA, 1'b1, {8'hFF, e}, v);
  endtask : rb

  task automatic set_addr(input logic [13:0] a);
    op(OP_START, 1'b0, 8'h00);
    wb(dw(1'b0), 1'b0);
    wb({2'b10, a[13:8]}, 1'b0);
    wb(a[7:0], 1'b0);
  endtask : set_addr

  task automatic poll(input logic ack);
    op(OP_START, 1'b0, 8'h00);
    wb(dw(1'b0), ack);
    op(OP_STOP, 1'b0, 8'h00);
  endtask : poll

  task automatic read_at(input logic [13:0] a, input logic [7:0] e0,
                         input logic [7:0] e1);
    set_addr(a);
    op(OP_START, 1'b0, 8'h00);
    wb(dw(1'b1), 1'b0);
    rb(1'b0, e0);
    rb(1'b1, e1);
    op(OP_STOP, 1'b0, 8'h00);
  endtask : read_at

  // ----------------------------------------------------------------
  // Scenarios and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    finish_test();
  end

  initial begin
    logic [13:0] base;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  d2;
    int          n;
    void'($urandom(28991));
    base = 14'($urandom() & 32'h3FC0);
    d0   = 8'($urandom());
    d1   = 8'($urandom());
    d2   = 8'($urandom());
    sel <= 3'($urandom());
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    // Page write from offset 62 wraps its third byte to offset 0.
    set_addr(base + 14'd62);
    wb(d0, 1'b0);
    wb(d1, 1'b0);
    wb(d2, 1'b0);
    op(OP_STOP, 1'b0, 8'h00);
    poll(1'b1);
    for (n = 0; n < 3000 && write_busy !== 1'b0; n++) @(posedge mclk);
    // A write cycle that never ends counts as a mismatch.
    if (write_busy !== 1'b0) begin
      err_total++;
      $display("Error %0t: write cycle did not end", $time);
    end
    poll(1'b0);
    read_at(base + 14'd62, d0, d1);
    read_at(base, d2, 8'h00);
    // Protected write: addresses acked, data refused, array untouched.
    wp <= 1'b1;
    set_addr(base + 14'd62);
    wb(~d0, 1'b1);
    op(OP_STOP, 1'b0, 8'h00);
    read_at(base + 14'd62, d0, d1);
    wp <= 1'b0;
    // Words with one select or type bit wrong get no answer.
    for (n = 0; n < 4; n++) begin
      op(OP_START, 1'b0, 8'h00);
      wb(dw(1'b0) ^ (8'h02 << n), 1'b1);
      op(OP_STOP, 1'b0, 8'h00);
    end
    finish_test();
  end
endmodule : ietp_tb_top
